// ==== design/spiwr_dev.sv ====
// Device end: serial slave holding the wiper and access control registers
//
// What this block does
// [RL1] Sample input on clock rise, select low only
// [RL2] Output changes on fall, host samples rise
// [RL3] Control bit 1 picks push-pull or open-drain
// [RL4] Select high: standby, output released
// [RL5] Select low enables active operation
// [RL6] Ignore traffic until first select fall
// [RL7] Wiper register sets tap, monotonic code
// [RL8] Wiper resets to mid-scale 80h
// [RL9] Reset: wiper at 80h, control at 40h
// [RL10] Control bit 6 low means shutdown
// [RL11] Shutdown keeps wiper value, restores on exit
// [RL12] Mode 0 slave, host owns clocks
// [RL13] Bytes travel most significant bit first
// [RL14] First byte opcode and address, then data
// [RL15] Address 10000 control, 0 or 1 wiper
// [RL16] Decode nop, control and addressed accesses
// [RL17] Writes take effect at select rise
// [RL18] Read frame echoes instruction then value
// [RL19] Chained read returns 111b address, data
// [RL20] Unknown opcodes, short frames change nothing
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module spiwr_dev
	import spiwr_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Serial link
	spiwr_if.dev link,
	// Potentiometer side
	output logic [7:0] wiper_position,
	output logic [7:0] wiper_tap,
	output logic array_open,
	output logic wiper_to_low,
	output logic standby
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic armed;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] rx_sr;
		logic [7:0] instr;
		logic [7:0] data;
		logic [7:0] tx_sr;
		logic [7:0] tx_next;
		logic pend;
		logic [7:0] pend_instr;
		logic [7:0] wiper;
		logic [7:0] access_control;
		logic sdo_o;
		logic sdo_oe;
		logic [7:0] tap;
		logic open;
		logic standby;
	} spiwr_dev_st_t;
	spiwr_dev_st_t q, d;
	logic [2:0] lv;
	logic [2:0] rs;
	logic [2:0] fl;
	// ****************************************
	// Decoding
	// ****************************************
	// Returns {control selected, wiper selected}
	function automatic logic [1:0] decode_target(input logic [7:0] ins);
		logic [1:0] t;
		t = 2'b00;
		case (ins[7:5])
			OP_ACR_RD, OP_ACR_WR:
				t = 2'b10; // RL16
			OP_RD, OP_WR:
			begin
				if (ins[4:0] == ADDR_ACR)
					t = 2'b10; // RL15
				else if (ins[4:0] == ADDR_WIPER || ins[4:0] == ADDR_WIPER_ALT)
					t = 2'b01; // RL15
			end
			default:
				t = 2'b00; // RL20
		endcase
		return t;
	endfunction
	function automatic logic is_read(input logic [7:0] ins);
		return ins[7:5] == OP_ACR_RD || ins[7:5] == OP_RD; // RL16
	endfunction
	function automatic logic is_write(input logic [7:0] ins);
		return ins[7:5] == OP_ACR_WR || ins[7:5] == OP_WR; // RL16
	endfunction
	function automatic logic [7:0] read_value(input logic [7:0] ins,
		input logic [7:0] wip, input logic [7:0] ctl);
		logic [1:0] t;
		logic [7:0] v;
		t = decode_target(ins);
		v = 8'h00;
		if (is_read(ins) && t[1])
			v = ctl;
		else if (is_read(ins) && t[0])
			v = wip;
		return v;
	endfunction
	// ****************************************
	// Link sampling
	// ****************************************
	// Host owns select and clock; both arrive asynchronously
	spiwr_sync #(
		.W(3)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({link.cs_n, link.sck, link.sdi}),
		.level(lv),
		.rise(rs),
		.fall(fl)
	); // RL12
	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic cs_low;
		logic active;
		logic [7:0] byte_in;
		logic [1:0] tgt;
		logic shutdown;
		logic od;
		cs_low = 1'b0;
		active = 1'b0;
		byte_in = 8'h00;
		tgt = 2'b00;
		shutdown = 1'b0;
		od = 1'b0;
		d = q;
		cs_low = ~lv[2];
		active = q.armed & cs_low; // RL5
		if (fl[2])
		begin
			d.armed = 1'b1; // RL6
			d.bit_cnt = 3'h0;
			d.byte_cnt = 3'h0;
			d.tx_sr = q.pend ? {OP_ECHO, q.pend_instr[4:0]} : 8'h00; // RL19
			d.tx_next = 8'h00;
		end
		else if (active && rs[1])
		begin
			byte_in = {q.rx_sr[6:0], lv[0]}; // RL13
			d.rx_sr = byte_in; // RL1
			d.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == BIT_LAST)
			begin
				if (q.byte_cnt == 3'h0)
					d.instr = byte_in; // RL14
				else
					d.data = byte_in; // RL14
				if (q.byte_cnt != BYTE_SAT)
					d.byte_cnt = q.byte_cnt + 3'h1;
				case (q.byte_cnt)
					3'h0:
						d.tx_next = q.pend ?
							read_value(q.pend_instr, q.wiper, q.access_control) : 8'h00; // RL19
					3'h1:
						d.tx_next = is_read(q.instr) ? q.instr : 8'h00; // RL18
					3'h2:
						d.tx_next = read_value(q.instr, q.wiper, q.access_control); // RL18
					default:
						d.tx_next = 8'h00;
				endcase
			end
		end
		else if (active && fl[1])
		begin
			// Byte boundary loads the next byte, otherwise shift
			if (q.bit_cnt == 3'h0)
				d.tx_sr = q.tx_next; // RL2
			else
				d.tx_sr = {q.tx_sr[6:0], 1'b0}; // RL13
		end
		else if (q.armed && rs[2])
		begin
			tgt = decode_target(q.instr);
			// Partial bytes or an instruction alone never write
			if (q.bit_cnt == 3'h0 && q.byte_cnt >= 3'h2 && is_write(q.instr))
			begin
				if (tgt[1])
					d.access_control = q.data & ACR_WMASK; // RL17
				if (tgt[0])
					d.wiper = q.data; // RL17
			end // RL20
			d.pend = q.bit_cnt == 3'h0 && q.byte_cnt == 3'h2 &&
				is_read(q.instr); // RL19
			d.pend_instr = q.instr;
		end
		od = d.access_control[ODRAIN_BIT];
		d.sdo_oe = (q.armed & cs_low) & (od ? ~d.tx_sr[7] : 1'b1); // RL3 RL4
		d.sdo_o = od ? 1'b0 : d.tx_sr[7]; // RL3
		d.standby = ~(q.armed & cs_low); // RL4
		shutdown = ~d.access_control[SHUTDOWN_N_BIT_BIT]; // RL10
		d.open = shutdown; // RL10
		d.tap = shutdown ? TAP_LOW : d.wiper; // RL7 RL11
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.wiper <= WIPER_RST; // RL8 RL9
			q.access_control <= ACR_RST; // RL9
			q.tap <= WIPER_RST;
			q.standby <= 1'b1;
		end
		else
			q <= d;
	end
	// ****************************************
	// Outputs
	// ****************************************
	assign link.sdo_o = q.sdo_o;
	assign link.sdo_oe = q.sdo_oe;
	assign wiper_position = q.wiper;
	assign wiper_tap = q.tap;
	assign array_open = q.open;
	assign wiper_to_low = q.open;
	assign standby = q.standby;
endmodule
`default_nettype wire

// ==== common/spiwr_pkg.sv ====
// Shared constants for the serial wiper register link
package spiwr_pkg;
	// ****************************************
	// Device register map
	// ****************************************
	localparam logic [4:0] ADDR_WIPER = 5'h00;
	localparam logic [4:0] ADDR_WIPER_ALT = 5'h01;
	localparam logic [4:0] ADDR_ACR = 5'h10;
	localparam logic [7:0] WIPER_RST = 8'h80;
	localparam logic [7:0] ACR_RST = 8'h40;
	localparam logic [7:0] ACR_WMASK = 8'h42;
	localparam int SHUTDOWN_N_BIT_BIT = 6;
	localparam int ODRAIN_BIT = 1;
	localparam logic [7:0] TAP_LOW = 8'h00;
	// ****************************************
	// Instruction byte
	// ****************************************
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_ACR_RD = 3'h1;
	localparam logic [2:0] OP_ACR_WR = 3'h3;
	localparam logic [2:0] OP_RD = 3'h4;
	localparam logic [2:0] OP_WR = 3'h6;
	localparam logic [2:0] OP_ECHO = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BYTE_SAT = 3'h7;
	// ****************************************
	// Host timing
	// ****************************************
	localparam int CLK_NS = 25;
	localparam int T_HALF_NS = 250;
	localparam int T_LEAD_NS = 250;
	localparam int T_LAG_NS = 250;
	localparam int T_CS_NS = 2000;
	localparam logic [7:0] HALF_CYC = 8'((T_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] LEAD_CYC = 8'((T_LEAD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] LAG_CYC = 8'((T_LAG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CS_CYC = 8'((T_CS_NS + CLK_NS - 1) / CLK_NS);
	// ****************************************
	// Host registers on AHB-Lite
	// ****************************************
	localparam logic [7:0] HREG_CTRL = 8'h00;
	localparam logic [7:0] HREG_TX = 8'h04;
	localparam logic [7:0] HREG_RX = 8'h08;
	localparam logic [7:0] HREG_STAT = 8'h0c;
	localparam int CTRL_START = 0;
	localparam int CTRL_NB_LSB = 4;
	localparam logic [2:0] SIZE_WORD = 3'h2;
endpackage

// ==== common/spiwr_if.sv ====
// Serial link between the wiper register device and its host
`timescale 1ns/100ps
`default_nettype none
interface spiwr_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo_o;
	logic sdo_oe;
	logic sdo;
	// Released line reads high: pull-up for open drain and for standby
	assign sdo = sdo_oe ? sdo_o : 1'b1;
	modport dev(input cs_n, input sck, input sdi, output sdo_o,
		output sdo_oe);
	modport host(output cs_n, output sck, output sdi, input sdo);
endinterface
`default_nettype wire

// ==== design/spiwr_sync.sv ====
// Two-flop synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module spiwr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Asynchronous inputs
	input wire logic [W-1:0] async_in,
	// Synchronised level and edges
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} spiwr_sync_st_t;
	spiwr_sync_st_t q, d;
	always_comb
	begin
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end
	// Edges compare second and third stage only
	assign level = q.s2;
	assign rise = q.s2 & ~q.s3;
	assign fall = ~q.s2 & q.s3;
endmodule
`default_nettype wire

// ==== design/spiwr_host.sv ====
// Host end: AHB-Lite controlled serial master for the wiper device
`timescale 1ns/100ps
`default_nettype none
module spiwr_host
	import spiwr_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial link
	spiwr_if.host link
);
	typedef enum logic [2:0] {
		H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG, H_GAP
	} spiwr_hst_t;
	typedef struct packed {
		spiwr_hst_t st;
		logic [7:0] cnt;
		logic [2:0] bit_idx;
		logic [1:0] byte_idx;
		logic [1:0] last_byte;
		logic [31:0] tx;
		logic [31:0] rx;
		logic cs_n;
		logic sck;
		logic sdi;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
	} spiwr_host_st_t;
	spiwr_host_st_t q, d;
	logic sdo_s;
	// Device answers asynchronously to our clock
	spiwr_sync #(
		.W(1)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(link.sdo),
		.level(sdo_s),
		.rise(),
		.fall()
	);
	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic busy;
		logic [31:0] sh;
		busy = 1'b0;
		sh = 32'h0;
		d = q;
		busy = q.st != H_IDLE;
		if (hsel && htrans[1] && hready && hsize == SIZE_WORD)
		begin
			d.wr_pend = hwrite;
			d.wr_addr = haddr[7:0];
			case (haddr[7:0])
				HREG_TX: d.hrdata = q.tx;
				HREG_RX: d.hrdata = q.rx;
				HREG_STAT: d.hrdata = {31'h0, busy};
				default: d.hrdata = 32'h0;
			endcase
		end
		else
			d.wr_pend = 1'b0;
		case (q.st)
			H_IDLE:
			begin
				if (q.wr_pend && q.wr_addr == HREG_TX)
					d.tx = hwdata;
				if (q.wr_pend && q.wr_addr == HREG_CTRL && hwdata[CTRL_START])
				begin
					d.st = H_LEAD;
					d.cnt = LEAD_CYC - 8'h1;
					d.cs_n = 1'b0; // RL6 RL17
					d.sdi = q.tx[31]; // RL13
					d.bit_idx = 3'h0;
					d.byte_idx = 2'h0;
					d.last_byte = hwdata[CTRL_NB_LSB +: 2];
					d.rx = 32'h0;
				end
			end
			H_LEAD, H_LOW:
			begin
				d.cnt = q.cnt - 8'h1;
				if (q.cnt == 8'h0)
				begin
					d.st = H_HIGH;
					d.cnt = HALF_CYC - 8'h1;
					d.sck = 1'b1; // RL12
					d.rx = {q.rx[30:0], sdo_s}; // RL2
				end
			end
			H_HIGH:
			begin
				d.cnt = q.cnt - 8'h1;
				if (q.cnt == 8'h0)
				begin
					d.sck = 1'b0; // RL12
					if (q.bit_idx == BIT_LAST && q.byte_idx == q.last_byte)
					begin
						d.st = H_LAG;
						d.cnt = LAG_CYC - 8'h1;
					end
					else
					begin
						sh = {q.tx[30:0], 1'b0};
						d.tx = sh;
						d.sdi = sh[31]; // RL13
						d.bit_idx = q.bit_idx + 3'h1;
						if (q.bit_idx == BIT_LAST)
							d.byte_idx = q.byte_idx + 2'h1;
						d.st = H_LOW;
						d.cnt = HALF_CYC - 8'h1;
					end
				end
			end
			H_LAG:
			begin
				d.cnt = q.cnt - 8'h1;
				if (q.cnt == 8'h0)
				begin
					d.cs_n = 1'b1; // RL17
					d.st = H_GAP;
					d.cnt = CS_CYC - 8'h1;
				end
			end
			H_GAP:
			begin
				d.cnt = q.cnt - 8'h1;
				if (q.cnt == 8'h0)
					d.st = H_IDLE;
			end
			default:
				d.st = H_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.st <= H_IDLE;
			q.cs_n <= 1'b1;
		end
		else
			q <= d;
	end
	// ****************************************
	// Outputs
	// ****************************************
	// Zero wait states: read data is prepared in the address phase
	assign hrdata = q.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign link.cs_n = q.cs_n;
	assign link.sck = q.sck;
	assign link.sdi = q.sdi;
endmodule
`default_nettype wire

// ==== verif/spiwr_chk.sv ====
// Concurrent checks on the serial wiper link
`timescale 1ns/100ps
`default_nettype none
module spiwr_chk (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Serial link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sdo
);
	logic sck_q;
	logic [3:0] fall_age_q;
	logic [3:0] high_len_q;

	// Cycles since the last serial clock fall, saturating
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sck_q <= 1'b0;
			fall_age_q <= 4'hf;
			high_len_q <= 4'h0;
		end
		else
		begin
			sck_q <= sck;
			// Length of the current high phase, saturating
			if (!sck)
				high_len_q <= 4'h0;
			else if (high_len_q != 4'hf)
				high_len_q <= high_len_q + 4'h1;
			if (sck_q && !sck)
				fall_age_q <= 4'h0;
			else if (fall_age_q != 4'hf)
				fall_age_q <= fall_age_q + 4'h1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****************************************
	// Link properties
	// ****************************************
	property p_idle_release;
		cs_n [*8] |-> !sdo_oe;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("output driven while deselected");
	property p_no_wake;
		cs_n && !sdo_oe |=> !sdo_oe;
	endproperty
	a_no_wake: assert property (p_no_wake)
		else $error("output enabled without select");
	property p_select_drive;
		$fell(cs_n) |-> ##[1:8] (sdo_oe || cs_n);
	endproperty
	a_select_drive: assert property (p_select_drive)
		else $error("output not enabled after select");
	// Settled frame: any line change must follow a clock fall closely
	property p_out_on_fall;
		!cs_n && !$past(cs_n, 8) && $changed(sdo) |-> fall_age_q < 4'h8;
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("output changed away from clock fall");
	property p_sdi_hold;
		$rose(sck) |-> $stable(sdi) [*8];
	endproperty
	a_sdi_hold: assert property (p_sdi_hold)
		else $error("input moved around clock rise");
	property p_idle_sck;
		cs_n |-> !sck;
	endproperty
	a_idle_sck: assert property (p_idle_sck)
		else $error("clock high while deselected");
	property p_sck_high;
		$fell(sck) |-> high_len_q == 4'ha;
	endproperty
	a_sck_high: assert property (p_sck_high)
		else $error("clock high phase wrong");
	property p_lead;
		$fell(cs_n) |-> !sck [*8];
	endproperty
	a_lead: assert property (p_lead)
		else $error("clock too soon after select");
	property p_gap;
		$rose(cs_n) |-> cs_n [*8];
	endproperty
	a_gap: assert property (p_gap)
		else $error("select reasserted too soon");
endmodule
`default_nettype wire

// ==== verif/spi_wiper_register_slave_test.sv ====
// Bench joining host and device ends of the wiper link
`timescale 1ns/100ps
`default_nettype none
module spi_wiper_register_slave_test
	import spiwr_pkg::*;
;
	logic hclk;
	logic hresetn;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = SIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [7:0] wiper_position;
	logic [7:0] wiper_tap;
	logic array_open;
	logic wiper_to_low;
	logic standby;
	logic [31:0] mon = 32'h0;
	logic sck_q = 1'b0;
	logic cs_q = 1'b1;
	logic hi_seen = 1'b0;
	int failures = 0;
	int checked = 0;

	spiwr_if link();
	assign hready = hreadyout;
	spiwr_host i_spiwr_host (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.link(link));
	spiwr_dev i_spiwr_dev (.hclk, .hresetn, .link(link), .wiper_position,
		.wiper_tap, .array_open, .wiper_to_low, .standby);
	spiwr_chk i_spiwr_chk (.hclk, .hresetn, .cs_n(link.cs_n),
		.sck(link.sck), .sdi(link.sdi), .sdo_o(link.sdo_o),
		.sdo_oe(link.sdo_oe), .sdo(link.sdo));

	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Wire monitor: input bits in clock order, any driven high
	always @(posedge hclk)
	begin
		sck_q <= link.sck;
		cs_q <= link.cs_n;
		if (cs_q && !link.cs_n)
			mon <= 32'h0;
		else if (link.sck && !sck_q && !link.cs_n)
			mon <= {mon[30:0], link.sdi};
		if (link.sdo_oe && link.sdo_o)
			hi_seen <= 1'b1;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic report_and_stop;
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ready and read data are taken at the same rising edge
	task automatic wait_rdy(output logic [31:0] rd);
		for (int n = 0; n < 50; n++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
			begin
				rd = hrdata;
				check({31'h0, hresp}, 32'h0);
				return;
			end
		end
		failures++;
		report_and_stop();
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rd);
	endtask
	// One frame of nb+1 bytes; returns the received bits
	task automatic frame(input logic [1:0] nb, input logic [31:0] tx,
		output logic [31:0] rx);
		logic [31:0] st;
		hi_seen = 1'b0;
		bus(1'b1, HREG_TX, tx, st);
		bus(1'b1, HREG_CTRL, {26'h0, nb, 4'h1}, st);
		for (int n = 0; n < 1500; n++)
		begin
			bus(1'b0, HREG_STAT, 32'h0, st);
			if (st[0] === 1'b0)
			begin
				bus(1'b0, HREG_RX, 32'h0, rx);
				return;
			end
		end
		failures++;
		report_and_stop();
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] rx;
		check(wiper_position, WIPER_RST);
		check(wiper_tap, WIPER_RST);
		check(standby, 1'b1);
		frame(2'd3, {OP_ACR_RD, 5'h0, 24'h0}, rx);
		check(rx, {16'h0, OP_ACR_RD, 5'h0, ACR_RST});
		check(hi_seen, 1'b1);
		frame(2'd3, {OP_RD, ADDR_WIPER, 24'h0}, rx);
		check(rx, {16'h0, OP_RD, ADDR_WIPER, WIPER_RST});
	endtask
	task automatic t_write;
		logic [31:0] rx;
		frame(2'd1, {OP_WR, ADDR_WIPER, 8'h5a, 16'h0}, rx);
		check(mon[15:0], {OP_WR, ADDR_WIPER, 8'h5a});
		check(wiper_position, 8'h5a);
		check(standby, 1'b1);
		frame(2'd1, {OP_WR, ADDR_WIPER_ALT, 8'h33, 16'h0}, rx);
		check(wiper_tap, 8'h33);
		frame(2'd2, {OP_WR, ADDR_WIPER, 8'h11, 8'h22, 8'h0}, rx);
		check(wiper_position, 8'h22);
	endtask
	task automatic t_shutdown;
		logic [31:0] rx;
		frame(2'd1, {OP_ACR_WR, 5'h1f, 8'h00, 16'h0}, rx);
		check({array_open, wiper_to_low, wiper_tap}, {2'b11, TAP_LOW});
		check(wiper_position, 8'h22);
		frame(2'd1, {OP_WR, ADDR_ACR, 8'hff, 16'h0}, rx);
		check({array_open, wiper_tap}, {1'b0, 8'h22});
		frame(2'd3, {OP_RD, ADDR_ACR, 24'h0}, rx);
		check(rx, {16'h0, OP_RD, ADDR_ACR, ACR_WMASK});
		check(hi_seen, 1'b0);
		frame(2'd1, {OP_ACR_WR, 5'h0, ACR_RST, 16'h0}, rx);
	endtask
	// Zero data: a wrongful write would show on tap or shutdown
	task automatic t_ignore;
		logic [31:0] rx;
		logic [7:0] ops [6] = '{8'he0, 8'h40, 8'ha0, 8'hc2, 8'hd1, 8'h00};
		foreach (ops[i])
		begin
			frame(2'd1, {ops[i], 24'h0}, rx);
			check({array_open, wiper_tap}, {1'b0, 8'h22});
		end
		frame(2'd0, {OP_WR, ADDR_WIPER, 24'h0}, rx);
		check(wiper_position, 8'h22);
	endtask
	task automatic t_chain;
		logic [31:0] rx;
		frame(2'd1, {OP_RD, ADDR_WIPER, 24'h0}, rx);
		frame(2'd1, {OP_NOP, 5'h0, 24'h0}, rx);
		check(rx[15:0], {OP_ECHO, ADDR_WIPER, 8'h22});
	endtask

	initial
	begin
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_write();
		t_shutdown();
		t_ignore();
		t_chain();
		report_and_stop();
	end
endmodule
`default_nettype wire
